// [bench/ald_fetch_model.sv]
// fetch-side model: presents one decoded request and holds it until taken
// assumes the core takes a request at an edge where busy is low
`timescale 1ns/1ps
`default_nettype none

module ald_fetch_model
	import ald_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// from bench
	input wire logic start_i,
	input wire ald_req_type cmd_i,
	// to and from core
	input wire logic busy_i,
	output logic req_valid_o,
	output ald_req_type req_o
);
	// ****************************************
	// request holding
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			req_valid_o <= 1'b0;
			req_o <= '0;
		end else if (start_i) begin
			req_valid_o <= 1'b1;
			req_o <= cmd_i;
		end else if (req_valid_o && !busy_i) begin
			req_valid_o <= 1'b0;
			req_o <= ~req_o;
		end
	end
endmodule
`default_nettype wire

// [bench/test_ald_core.sv]
// bench for the arithmetic/logic execute core
// assumes one processor state per clock, requests come from the fetch model
`timescale 1ns/1ps
`default_nettype none

module test_ald_core
	import ald_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic start = 1'b0;
	ald_req_type cmd = '0;
	logic req_valid;
	ald_req_type req;
	logic busy_o, done_o, err_o, escape_o;
	ald_rsp_type rsp_o;
	logic [3:0] states_o, idle_o;
	logic [2:0] bytes_o;
	int bad_count = 0;
	int total_checks = 0;

	// ****************************************
	// clock, instances
	// ****************************************
	initial begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	ald_fetch_model i_ald_fetch_model (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.start_i(start), .cmd_i(cmd), .busy_i(busy_o), .req_valid_o(req_valid), .req_o(req));

	ald_core i_ald_core (.core_clk_i(core_clk_i), .reset_i(reset_i), .req_valid_i(req_valid),
		.req_i(req), .busy_o(busy_o), .done_o(done_o), .err_o(err_o), .rsp_o(rsp_o),
		.states_o(states_o), .idle_o(idle_o), .bytes_o(bytes_o), .escape_o(escape_o));

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic results();
		if (bad_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// issue one request, count states to done, compare answer
	task automatic run(input ald_op_type o, input ald_form_type f, input ald_mem_mode_type m,
		input logic far, input logic [15:0] d, input logic [15:0] s, input logic [15:0] imm,
		input ald_psw_type fin, input logic [15:0] ed, input ald_psw_type ef,
		input logic [3:0] est, input logic [2:0] eby, input logic ew);
		int n;
		n = 0;
		@(posedge core_clk_i);
		cmd <= '{op: o, form: f, mem_mode: m, far_area: far, dst: d, src: s,
			imm_lo: imm[7:0], imm_hi: imm[15:8], flags: fin};
		start <= 1'b1;
		@(posedge core_clk_i);
		start <= 1'b0;
		// the fetch model drops valid at the edge where the core takes it
		do begin
			@(posedge core_clk_i);
			#1;
		end while (req_valid === 1'b1);
		do begin
			@(posedge core_clk_i);
			n++;
			#1;
		end while (done_o !== 1'b1 && n < 20);
		chk(n == est && states_o === est, "state count");
		chk(bytes_o === eby, "byte count");
		chk(escape_o === (f == ALD_FM_SFR_IMM || f == ALD_FM_ACC_SFR), "escape byte");
		chk(rsp_o.flags === ef, "flags");
		chk(rsp_o.write === ew && busy_o === 1'b0, "write strobe");
		chk(rsp_o.form === f, "form echo");
		if (ew) begin
			chk(rsp_o.data === ed, "result");
		end
	endtask

	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		repeat (5000) @(posedge core_clk_i);
		bad_count++;
		results();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (8) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(posedge core_clk_i);
		run(ALD_OP_ADD_WITH_CARRY, ALD_FM_ACC_IMM, ALD_MM_REG_INDIRECT, 1'b0, 16'h007F, 16'h0000,
			16'h0000, 6'h01, 16'h0080, 6'h2C, 4'h3, 3'h2, 1'b1);
		run(ALD_OP_ADD_WITH_CARRY, ALD_FM_SADDR_SADDR, ALD_MM_REG_INDIRECT, 1'b1, 16'h00FF,
			16'h0000, 16'h0000, 6'h01, 16'h0000, 6'h19, 4'h9, 3'h3, 1'b1);
		run(ALD_OP_ADD_WITH_CARRY, ALD_FM_MEM_ACC, ALD_MM_BASE, 1'b0, 16'h0010, 16'h0005,
			16'h0000, 6'h00, 16'h0015, 6'h00, 4'h8, 3'h3, 1'b1);
		run(ALD_OP_ADD_WITH_CARRY, ALD_FM_ACC_SFR, ALD_MM_REG_INDIRECT, 1'b0, 16'h0001, 16'h0001,
			16'h0000, 6'h00, 16'h0002, 6'h00, 4'h7, 3'h3, 1'b1);
		run(ALD_OP_SUB, ALD_FM_SADDR_IMM, ALD_MM_REG_INDIRECT, 1'b0, 16'h0005, 16'h0000,
			16'h0006, 6'h00, 16'h00FF, 6'h2B, 4'h5, 3'h3, 1'b1);
		run(ALD_OP_SUBTRACT_WITH_BORROW, ALD_FM_SADDR_IMM, ALD_MM_REG_INDIRECT, 1'b1, 16'h0080,
			16'h0000, 16'h0000, 6'h01, 16'h007F, 6'h0E, 4'h7, 3'h3, 1'b1);
		run(ALD_OP_SUBTRACT_WITH_BORROW, ALD_FM_ACC_SADDR, ALD_MM_REG_INDIRECT, 1'b1, 16'h0000,
			16'h0000, 16'h0000, 6'h00, 16'h0000, 6'h12, 4'h4, 3'h2, 1'b1);
		run(ALD_OP_SUBTRACT_WITH_BORROW, ALD_FM_MEM_ACC, ALD_MM_REG_INDIRECT, 1'b0, 16'h0000,
			16'h0001, 16'h0000, 6'h01, 16'h00FE, 6'h2B, 4'h7, 3'h2, 1'b1);
		chk(idle_o === 4'h2, "idle count");
		run(ALD_OP_AND, ALD_FM_ACC_IMM, ALD_MM_REG_INDIRECT, 1'b0, 16'h00F0, 16'h0000,
			16'h000F, 6'h2B, 16'h0000, 6'h1D, 4'h3, 3'h2, 1'b1);
		run(ALD_OP_OR, ALD_FM_SADDR_SADDR, ALD_MM_REG_INDIRECT, 1'b0, 16'h0001, 16'h0002,
			16'h0000, 6'h00, 16'h0003, 6'h04, 4'h6, 3'h3, 1'b1);
		run(ALD_OP_XOR, ALD_FM_SADDR_SADDR, ALD_MM_REG_INDIRECT, 1'b1, 16'h0081, 16'h0000,
			16'h0000, 6'h01, 16'h0081, 6'h25, 4'h9, 3'h3, 1'b1);
		run(ALD_OP_COMPARE, ALD_FM_SADDR_SADDR, ALD_MM_REG_INDIRECT, 1'b1, 16'h0001, 16'h0002,
			16'h0000, 6'h00, 16'h0000, 6'h2B, 4'h8, 3'h3, 1'b0);
		run(ALD_OP_WORD_ADD, ALD_FM_SADDR_IMM, ALD_MM_REG_INDIRECT, 1'b0, 16'h00FF, 16'h0000,
			16'h0102, 6'h00, 16'h0201, 6'h08, 4'h5, 3'h4, 1'b1);
		run(ALD_OP_WORD_ADD, ALD_FM_SADDR_SADDR, ALD_MM_REG_INDIRECT, 1'b1, 16'h8000, 16'h8000,
			16'h0000, 6'h01, 16'h0000, 6'h15, 4'h9, 3'h3, 1'b1);
		run(ALD_OP_WORD_SUBTRACT, ALD_FM_SADDR_IMM, ALD_MM_REG_INDIRECT, 1'b1, 16'h0000,
			16'h0000, 16'h0001, 6'h00, 16'hFFFF, 6'h2B, 4'h7, 3'h4, 1'b1);
		// word op on a memory form is refused with an error pulse
		@(posedge core_clk_i);
		cmd <= '{op: ALD_OP_WORD_ADD, form: ALD_FM_ACC_MEM, mem_mode: ALD_MM_REG_INDIRECT,
			default: '0};
		start <= 1'b1;
		@(posedge core_clk_i);
		start <= 1'b0;
		@(posedge core_clk_i);
		#1;
		chk(err_o === 1'b1 && busy_o === 1'b0 && states_o === 4'h7, "memory word op not refused");
		@(posedge core_clk_i);
		#1;
		chk(err_o === 1'b0 && done_o === 1'b0, "error pulse too long");
		results();
	end
endmodule
`default_nettype wire

// [hw/ald_core.sv]
// execute unit for the 8-bit arithmetic/logic group and word add/subtract
// assumes fetch has decoded operation and form and presents operand values
//
// How it works
// - acc add-with-carry immediate: 2 bytes, 3 states
// - direct pair add-with-carry: 3 bytes, 6/9 states
// - memory destination add-with-carry: 7-8 states, 2-4 bytes
// - sfr forms carry escape byte; acc-sfr 3 bytes, 7; sfr-imm 4 bytes, 10
// - direct minus immediate: borrow, sub set, 5/7
// - subtract-with-borrow immediate also subtracts incoming carry
// - acc subtract-with-borrow direct: 3/4 states, 2 bytes
// - memory subtract-with-borrow: 7-8 states, 2-3 idle
// - logical: sign, zero, parity; sub cleared, carries kept
// - or pair stores result, 6/9 states, 3 bytes
// - xor pair stores result, logical flags
// - compare updates flags only, discards difference
// - word add immediate low byte first, 4 bytes
// - word pair add writes sum, arithmetic flags
// - word subtract immediate: borrow, sub set, 5/7
// - unaffected flags keep their previous value
`timescale 1ns/1ps
`default_nettype none

module ald_core
	import ald_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// request
	input wire logic req_valid_i,
	input wire ald_req_type req_i,
	// answer
	output logic busy_o,
	output logic done_o,
	output logic err_o,
	output ald_rsp_type rsp_o,
	// timing and length
	output logic [3:0] states_o,
	output logic [3:0] idle_o,
	output logic [2:0] bytes_o,
	output logic escape_o
);

	typedef struct packed {
		ald_fsm_type fsm;
		logic [3:0] cnt;
		logic busy;
		logic done;
		logic err;
		logic wr_pend;
		ald_rsp_type rsp;
		logic [3:0] states;
		logic [3:0] idle;
		logic [2:0] bytes;
		logic escape;
	} ald_state_type;

	ald_state_type st_ff;
	ald_state_type nxt_st;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic is_word(input ald_op_type op);
		return op == ALD_OP_WORD_ADD || op == ALD_OP_WORD_SUBTRACT;
	endfunction

	function automatic logic is_mem(input ald_form_type f);
		return f == ALD_FM_ACC_MEM || f == ALD_FM_MEM_ACC;
	endfunction

	function automatic logic [3:0] state_count(input ald_req_type r);
		logic [3:0] n;
		logic slow;
		slow = r.mem_mode != ALD_MM_REG_INDIRECT;
		case (r.form)
			ALD_FM_ACC_IMM, ALD_FM_REG_REG: n = ALD_ST_ACC_IMM;
			ALD_FM_SADDR_IMM: n = r.far_area ? ALD_ST_SADDR_IMM_FAR : ALD_ST_SADDR_IMM;
			ALD_FM_SFR_IMM: n = ALD_ST_SFR_IMM;
			ALD_FM_ACC_SADDR: n = r.far_area ? ALD_ST_ACC_SADDR_FAR : ALD_ST_ACC_IMM;
			ALD_FM_ACC_SFR: n = ALD_ST_ACC_SFR;
			ALD_FM_SADDR_SADDR: begin
				if (!r.far_area)
					n = ALD_ST_PAIR;
				else if (r.op == ALD_OP_COMPARE)
					n = ALD_ST_COMPARE_PAIR_FAR;
				else
					n = ALD_ST_PAIR_FAR;
			end
			ALD_FM_ACC_MEM: n = ALD_ST_ACC_MEM + 4'(slow);
			ALD_FM_MEM_ACC: begin
				n = (r.op == ALD_OP_COMPARE) ? ALD_ST_ACC_MEM : ALD_ST_MEM_ACC;
				n = n + 4'(slow);
			end
			default: n = ALD_ST_ACC_IMM;
		endcase
		// word forms that end in the accumulator pair or registers take one more
		if (is_word(r.op) && (r.form == ALD_FM_ACC_IMM || r.form == ALD_FM_REG_REG ||
			r.form == ALD_FM_ACC_SADDR || r.form == ALD_FM_ACC_SFR))
			n = n + ALD_ST_WORD_EXTRA;
		return n;
	endfunction

	function automatic logic [3:0] idle_count(input ald_req_type r);
		logic [3:0] n;
		logic slow;
		logic cmp;
		slow = r.mem_mode != ALD_MM_REG_INDIRECT;
		cmp = r.op == ALD_OP_COMPARE;
		case (r.form)
			ALD_FM_ACC_IMM, ALD_FM_REG_REG: n = ALD_ID_SHORT + 4'(is_word(r.op));
			ALD_FM_SADDR_IMM, ALD_FM_SADDR_SADDR: n = cmp ? ALD_ID_ONE : ALD_ID_NONE;
			ALD_FM_SFR_IMM: n = ALD_ID_SHORT + 4'(cmp);
			ALD_FM_ACC_SADDR: n = ALD_ID_ONE + 4'(is_word(r.op));
			ALD_FM_ACC_SFR: n = ALD_ID_ACC_MEM + 4'(is_word(r.op));
			ALD_FM_ACC_MEM: n = ALD_ID_ACC_MEM + 4'(slow);
			ALD_FM_MEM_ACC: n = ALD_ID_MEM_ACC + 4'(cmp) + 4'(slow);
			default: n = ALD_ID_NONE;
		endcase
		// word subtract of the accumulator pair by immediate idles one less
		if (r.op == ALD_OP_WORD_SUBTRACT && r.form == ALD_FM_ACC_IMM)
			n = ALD_ID_SHORT;
		return n;
	endfunction

	function automatic logic [2:0] byte_count(input ald_req_type r);
		logic [2:0] n;
		case (r.form)
			ALD_FM_ACC_IMM: n = is_word(r.op) ? ALD_BY_THREE : ALD_BY_TWO;
			ALD_FM_SADDR_IMM: n = is_word(r.op) ? ALD_BY_FOUR : ALD_BY_THREE;
			ALD_FM_SFR_IMM: n = is_word(r.op) ? ALD_BY_FIVE : ALD_BY_FOUR;
			ALD_FM_ACC_SFR, ALD_FM_SADDR_SADDR: n = ALD_BY_THREE;
			ALD_FM_ACC_MEM, ALD_FM_MEM_ACC: begin
				case (r.mem_mode)
					ALD_MM_BASE: n = ALD_BY_THREE;
					ALD_MM_INDEX: n = ALD_BY_FOUR;
					default: n = ALD_BY_TWO;
				endcase
			end
			default: n = ALD_BY_TWO;
		endcase
		return n;
	endfunction

	// ****************************************
	// next state and datapath
	// ****************************************
	always_comb begin
		logic [15:0] opa;
		logic [15:0] opb;
		logic [16:0] wres;
		logic [8:0] bres;
		logic [4:0] nib;
		logic cin;
		logic subtract;
		logic logical;
		logic [15:0] res;
		ald_psw_type fl;
		opa = '0;
		opb = '0;
		wres = '0;
		bres = '0;
		nib = '0;
		cin = 1'b0;
		subtract = 1'b0;
		logical = 1'b0;
		res = '0;
		fl = req_i.flags;
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.err = 1'b0;
		nxt_st.rsp.write = 1'b0;
		case (st_ff.fsm)
			ALD_ST_IDLE: begin
				if (req_valid_i && is_word(req_i.op) && is_mem(req_i.form)) begin
					nxt_st.err = 1'b1;
				end else if (req_valid_i) begin
					opa = req_i.dst;
					opb = (req_i.form == ALD_FM_ACC_IMM || req_i.form == ALD_FM_SADDR_IMM ||
						req_i.form == ALD_FM_SFR_IMM) ? {req_i.imm_hi, req_i.imm_lo} : req_i.src;
					cin = (req_i.op == ALD_OP_ADD_WITH_CARRY ||
						req_i.op == ALD_OP_SUBTRACT_WITH_BORROW) && req_i.flags.carry_flag;
					subtract = req_i.op == ALD_OP_SUB || req_i.op == ALD_OP_SUBTRACT_WITH_BORROW ||
						req_i.op == ALD_OP_COMPARE || req_i.op == ALD_OP_WORD_SUBTRACT;
					logical = req_i.op == ALD_OP_AND || req_i.op == ALD_OP_OR ||
						req_i.op == ALD_OP_XOR;
					if (subtract) begin
						bres = {1'b0, opa[7:0]} - {1'b0, opb[7:0]} - 9'(cin);
						nib = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - 5'(cin);
						wres = {1'b0, opa} - {1'b0, opb};
					end else begin
						bres = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + 9'(cin);
						nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + 5'(cin);
						wres = {1'b0, opa} + {1'b0, opb};
					end
					case (req_i.op)
						ALD_OP_AND: res = {8'h00, opa[7:0] & opb[7:0]};
						ALD_OP_OR: res = {8'h00, opa[7:0] | opb[7:0]};
						ALD_OP_XOR: res = {8'h00, opa[7:0] ^ opb[7:0]};
						ALD_OP_WORD_ADD, ALD_OP_WORD_SUBTRACT: res = wres[15:0];
						default: res = {8'h00, bres[7:0]};
					endcase
					fl.sub = subtract;
					if (is_word(req_i.op)) begin
						fl.s = res[15];
						fl.z = res == 16'h0000;
						fl.carry_flag = wres[16];
						fl.pv = subtract ? (opa[15] != opb[15]) && (res[15] != opa[15])
							: (opa[15] == opb[15]) && (res[15] != opa[15]);
					end else begin
						fl.s = res[7];
						fl.z = res[7:0] == 8'h00;
						fl.pv = subtract ? (opa[7] != opb[7]) && (res[7] != opa[7])
							: (opa[7] == opb[7]) && (res[7] != opa[7]);
						fl.carry_flag = bres[8];
					end
					fl.aux_carry_flag = nib[4];
					if (logical) begin
						fl.pv = ~^res[7:0];
						fl.aux_carry_flag = req_i.flags.aux_carry_flag;
						fl.carry_flag = req_i.flags.carry_flag;
					end
					nxt_st.fsm = ALD_ST_EXEC;
					nxt_st.busy = 1'b1;
					nxt_st.cnt = state_count(req_i);
					nxt_st.states = state_count(req_i);
					nxt_st.idle = idle_count(req_i);
					nxt_st.bytes = byte_count(req_i);
					nxt_st.escape = req_i.form == ALD_FM_SFR_IMM ||
						req_i.form == ALD_FM_ACC_SFR;
					nxt_st.wr_pend = req_i.op != ALD_OP_COMPARE;
					nxt_st.rsp.data = res;
					nxt_st.rsp.flags = fl;
					nxt_st.rsp.form = req_i.form;
				end
			end
			ALD_ST_EXEC: begin
				if (st_ff.cnt == 4'h1) begin
					nxt_st.fsm = ALD_ST_IDLE;
					nxt_st.busy = 1'b0;
					nxt_st.done = 1'b1;
					nxt_st.rsp.write = st_ff.wr_pend;
				end else begin
					nxt_st.cnt = st_ff.cnt - 4'h1;
				end
			end
			default: nxt_st.fsm = ALD_ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_ff <= '{fsm: ALD_ST_IDLE, rsp: '{form: ALD_FM_ACC_IMM, default: '0}, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign busy_o = st_ff.busy;
	assign done_o = st_ff.done;
	assign err_o = st_ff.err;
	assign rsp_o = st_ff.rsp;
	assign states_o = st_ff.states;
	assign idle_o = st_ff.idle;
	assign bytes_o = st_ff.bytes;
	assign escape_o = st_ff.escape;

	// ****************************************
	// checks
	// ****************************************
	logic take;
	assign take = st_ff.fsm == ALD_ST_IDLE && req_valid_i &&
		!(is_word(req_i.op) && is_mem(req_i.form));

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence take_s(ald_op_type o, ald_form_type f, logic c);
		take && req_i.op == o && req_i.form == f && c;
	endsequence

	acc_carry_add_a: assert property (take_s(ALD_OP_ADD_WITH_CARRY, ALD_FM_ACC_IMM, 1'b1)
		|-> ##4 done_o && rsp_o.write && bytes_o == 3'h2 &&
		rsp_o.data[7:0] == 8'($past(req_i.dst[7:0], 4) + $past(req_i.imm_lo, 4) +
		8'($past(req_i.flags.carry_flag, 4))))
		else $error("accumulator add-with-carry wrong");
	pair_carry_add_a: assert property (take_s(ALD_OP_ADD_WITH_CARRY, ALD_FM_SADDR_SADDR,
		req_i.far_area) |-> ##1 !done_o [*8] ##2 done_o && rsp_o.write)
		else $error("direct pair add-with-carry timing wrong");
	mem_carry_add_a: assert property (take_s(ALD_OP_ADD_WITH_CARRY, ALD_FM_MEM_ACC,
		req_i.mem_mode == ALD_MM_REG_INDIRECT) |-> ##8 done_o && rsp_o.write)
		else $error("memory add-with-carry timing wrong");
	sfr_escape_a: assert property (take && req_i.form == ALD_FM_ACC_SFR
		&& !is_word(req_i.op) |-> ##8 done_o && escape_o && bytes_o == 3'h3)
		else $error("sfr form length wrong");
	sub_imm_flag_a: assert property (take_s(ALD_OP_SUB, ALD_FM_SADDR_IMM, !req_i.far_area)
		|-> ##6 done_o && rsp_o.flags.sub && states_o == 4'h5)
		else $error("subtract immediate wrong");
	borrow_imm_a: assert property (take_s(ALD_OP_SUBTRACT_WITH_BORROW,
		ALD_FM_SADDR_IMM, 1'b1) |-> ##1 (rsp_o.data[7:0] == 8'($past(req_i.dst[7:0]) -
		$past(req_i.imm_lo) - 8'($past(req_i.flags.carry_flag)))) ##[5:7] done_o)
		else $error("subtract-with-borrow immediate wrong");
	acc_borrow_a: assert property (take_s(ALD_OP_SUBTRACT_WITH_BORROW, ALD_FM_ACC_SADDR,
		req_i.far_area) |-> ##1 busy_o [*4] ##1 done_o && bytes_o == 3'h2)
		else $error("accumulator subtract-with-borrow timing wrong");
	mem_borrow_idle_a: assert property (done_o && rsp_o.form == ALD_FM_MEM_ACC
		&& rsp_o.write |-> states_o inside {4'h7, 4'h8} && idle_o inside {4'h2, 4'h3})
		else $error("memory subtract idle count wrong");
	logic_flags_a: assert property (take && req_i.op inside {ALD_OP_AND, ALD_OP_OR, ALD_OP_XOR}
		|-> ##1 (!rsp_o.flags.sub &&
		rsp_o.flags.carry_flag == $past(req_i.flags.carry_flag) &&
		rsp_o.flags.pv == ~^rsp_o.data[7:0]) ##[3:10] done_o)
		else $error("logical flags wrong");
	flag_keep_a: assert property (take && req_i.op inside {ALD_OP_AND, ALD_OP_OR, ALD_OP_XOR}
		|-> ##1 rsp_o.flags.aux_carry_flag == $past(req_i.flags.aux_carry_flag))
		else $error("unaffected flag changed");
	compare_discard_a: assert property (take_s(ALD_OP_COMPARE, ALD_FM_SADDR_SADDR, 1'b1)
		|-> ##[7:9] done_o && !rsp_o.write && rsp_o.flags.sub)
		else $error("compare must not write");
	word_add_imm_a: assert property (take_s(ALD_OP_WORD_ADD, ALD_FM_SADDR_IMM,
		!req_i.far_area) |-> ##6 done_o && bytes_o == 3'h4 &&
		rsp_o.data == 16'($past(req_i.dst, 6) + {$past(req_i.imm_hi, 6), $past(req_i.imm_lo, 6)}))
		else $error("word add immediate wrong");
	idle_quiet_a: assert property (st_ff.fsm == ALD_ST_IDLE |-> !busy_o)
		else $error("busy while idle");

endmodule

`default_nettype wire

// [hw/ald_pkg.sv]
// types and constants for the arithmetic/logic decode-execute block
// assumes one processor state per core clock cycle
package ald_pkg;

	// ****************************************
	// operations and operand forms
	// ****************************************
	typedef enum logic [3:0] {
		ALD_OP_ADD, ALD_OP_ADD_WITH_CARRY, ALD_OP_SUB, ALD_OP_SUBTRACT_WITH_BORROW,
		ALD_OP_AND, ALD_OP_OR, ALD_OP_XOR, ALD_OP_COMPARE, ALD_OP_WORD_ADD,
		ALD_OP_WORD_SUBTRACT
	} ald_op_type;

	typedef enum logic [3:0] {
		ALD_FM_ACC_IMM, ALD_FM_SADDR_IMM, ALD_FM_SFR_IMM, ALD_FM_REG_REG,
		ALD_FM_ACC_SADDR, ALD_FM_ACC_SFR, ALD_FM_SADDR_SADDR, ALD_FM_ACC_MEM,
		ALD_FM_MEM_ACC
	} ald_form_type;

	typedef enum logic [1:0] {
		ALD_MM_REG_INDIRECT, ALD_MM_BASE_INDEX, ALD_MM_BASE, ALD_MM_INDEX
	} ald_mem_mode_type;

	typedef enum logic [1:0] {
		ALD_ST_IDLE = 2'h1,
		ALD_ST_EXEC = 2'h2
	} ald_fsm_type;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic s;
		logic z;
		logic aux_carry_flag;
		logic pv;
		logic sub;
		logic carry_flag;
	} ald_psw_type;

	typedef struct packed {
		ald_op_type op;
		ald_form_type form;
		ald_mem_mode_type mem_mode;
		logic far_area;
		logic [15:0] dst;
		logic [15:0] src;
		logic [7:0] imm_lo;
		logic [7:0] imm_hi;
		ald_psw_type flags;
	} ald_req_type;

	typedef struct packed {
		logic [15:0] data;
		ald_psw_type flags;
		logic write;
		ald_form_type form;
	} ald_rsp_type;

	// ****************************************
	// processor state counts
	// ****************************************
	localparam logic [3:0] ALD_ST_ACC_IMM = 4'h3;
	localparam logic [3:0] ALD_ST_SADDR_IMM = 4'h5;
	localparam logic [3:0] ALD_ST_SADDR_IMM_FAR = 4'h7;
	localparam logic [3:0] ALD_ST_SFR_IMM = 4'hA;
	localparam logic [3:0] ALD_ST_ACC_SADDR_FAR = 4'h4;
	localparam logic [3:0] ALD_ST_ACC_SFR = 4'h7;
	localparam logic [3:0] ALD_ST_PAIR = 4'h6;
	localparam logic [3:0] ALD_ST_PAIR_FAR = 4'h9;
	localparam logic [3:0] ALD_ST_COMPARE_PAIR_FAR = 4'h8;
	localparam logic [3:0] ALD_ST_ACC_MEM = 4'h6;
	localparam logic [3:0] ALD_ST_MEM_ACC = 4'h7;
	localparam logic [3:0] ALD_ST_WORD_EXTRA = 4'h1;

	// ****************************************
	// idle state counts
	// ****************************************
	localparam logic [3:0] ALD_ID_NONE = 4'h0;
	localparam logic [3:0] ALD_ID_ONE = 4'h1;
	localparam logic [3:0] ALD_ID_MEM_ACC = 4'h2;
	localparam logic [3:0] ALD_ID_SHORT = 4'h3;
	localparam logic [3:0] ALD_ID_ACC_MEM = 4'h4;

	// ****************************************
	// instruction byte counts
	// ****************************************
	localparam logic [2:0] ALD_BY_TWO = 3'h2;
	localparam logic [2:0] ALD_BY_THREE = 3'h3;
	localparam logic [2:0] ALD_BY_FOUR = 3'h4;
	localparam logic [2:0] ALD_BY_FIVE = 3'h5;

endpackage
